//--- vic_pkg.sv
// Package of register map, field positions, reset values and vector numbers
`default_nettype none
package vic_pkg;
  // Register byte addresses
  localparam logic [15:0] VIC_SYSCTL_ADDR   = 16'hFFC4;
  localparam logic [15:0] VIC_SENSE_ADDR    = 16'hFFC6;
  localparam logic [15:0] VIC_ENABLE_ADDR   = 16'hFFC7;
  localparam logic [15:0] VIC_KMASK_LO_ADDR = 16'hFFF1;
  localparam logic [15:0] VIC_KMASK_HI_ADDR = 16'hFFF3;
  localparam logic [15:0] VIC_STATUS_ADDR   = 16'hFFC8;
  localparam logic [15:0] VIC_IMASK_ADDR    = 16'hFFC9;
  localparam logic [15:0] VIC_PEND_ADDR     = 16'hFFCA;
  // Field positions and reset values
  localparam int          VIC_NMI_EDGE_BIT  = 2;
  localparam logic [7:0]  VIC_SYSCTL_RST    = 8'h09;
  localparam logic [7:0]  VIC_SYSCTL_WMASK  = 8'hF7;
  localparam logic [7:0]  VIC_SENSE_RST     = 8'h00;
  localparam logic [7:0]  VIC_ENABLE_RST    = 8'h00;
  localparam logic [7:0]  VIC_KMASK_LO_RST  = 8'hBF;
  localparam logic [7:0]  VIC_KMASK_HI_RST  = 8'hFF;
  localparam logic [7:0]  VIC_IMASK_RST     = 8'h00;
  // Vector numbers
  localparam logic [5:0]  VIC_VEC_NMI       = 6'h03;
  localparam logic [5:0]  VIC_VEC_EXT0      = 6'h04;
  localparam logic [5:0]  VIC_VEC_INT0      = 6'h0C;
  localparam logic [5:0]  VIC_VEC_WDT       = 6'h24;
  localparam logic [5:0]  VIC_VEC_LAST      = 6'h25;
  localparam int          VIC_NUM_EXT       = 8;
  localparam int          VIC_NUM_KEY       = 16;
  localparam int          VIC_NUM_INT       = 26;
  localparam int          VIC_KEY_LINE      = 6;
  localparam int          VIC_WDT_INDEX     = 24;
  // Status bits of the event register
  localparam int          VIC_EV_NMI        = 0;
  localparam int          VIC_EV_TAKEN      = 1;
  localparam int          VIC_EV_EXT        = 2;
endpackage : vic_pkg
`default_nettype wire

//--- vic_top.sv
// Prioritising vectored interrupt controller with a Wishbone register slave
//
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
module vic_top
  import vic_pkg::*;
#(
  parameter int NUM_EXT = VIC_NUM_EXT,
  parameter int NUM_KEY = VIC_NUM_KEY,
  parameter int NUM_INT = VIC_NUM_INT
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [15:0]        wb_adr_i,
  input  wire logic [0:0]         wb_sel_i,
  input  wire logic [7:0]         wb_dat_i,
  output logic      [7:0]         wb_dat_o,
  output logic                    wb_ack_o,
  // Pins, active low
  input  wire logic               nonmask_n_i,
  input  wire logic [NUM_EXT-1:0] ext_request_lines_n_i,
  input  wire logic [NUM_KEY-1:0] key_sense_inputs_n_i,
  // On-chip sources, same clock
  input  wire logic [NUM_INT-1:0] int_request_i,
  input  wire logic               wdt_overflow_i,
  input  wire logic               wdt_nmi_mode_i,
  // CPU side
  input  wire logic               cpu_mask_i,
  input  wire logic               cpu_ack_i,
  output logic                    cpu_req_o,
  output logic      [5:0]         cpu_vec_num_o,
  output logic      [15:0]        cpu_vec_addr_o,
  output logic                    irq_o
);

  // Registers
  logic [7:0]         system_control_reg;
  logic [7:0]         request_sense_control_reg;
  logic [7:0]         request_enable_reg;
  logic [7:0]         key_mask_low_reg;
  logic [7:0]         key_mask_high_reg;
  logic [7:0]         status_reg;
  logic [7:0]         imask_reg;
  logic [NUM_EXT-1:0] edge_pend_reg;
  logic               nmi_pend_reg;
  logic               hold_reg;
  logic [5:0]         vec_reg;
  logic               ack_reg;
  logic [7:0]         rdata_next;

  // Three-stage pin synchronisers
  logic [2:0]         nmi_sync_reg;
  logic [NUM_EXT-1:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [NUM_KEY-1:0] key_s1_reg, key_s2_reg, key_s3_reg;
  logic               nmi_lvl_reg;
  logic [NUM_EXT-1:0] line_lvl_reg;

  // Bus decode
  logic wr_en, rd_en;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~ack_reg;
  assign rd_en = wb_cyc_i & wb_stb_i & ~ack_reg;

  function automatic logic hit(input logic [15:0] a);
    hit = wr_en && (wb_adr_i == a);
  endfunction : hit

  // Synchroniser chains, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_sync_reg <= 3'b111;
      ext_s1_reg   <= '1;
      ext_s2_reg   <= '1;
      ext_s3_reg   <= '1;
      key_s1_reg   <= '1;
      key_s2_reg   <= '1;
      key_s3_reg   <= '1;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], nonmask_n_i};
      ext_s1_reg   <= ext_request_lines_n_i;
      ext_s2_reg   <= ext_s1_reg;
      ext_s3_reg   <= ext_s2_reg;
      key_s1_reg   <= key_sense_inputs_n_i;
      key_s2_reg   <= key_s1_reg;
      key_s3_reg   <= key_s2_reg;
    end
  end

  // Key inputs folded onto line 6 with their own masks
  logic [NUM_KEY-1:0] key_agree;
  logic               key_active;
  logic [NUM_EXT-1:0] line_agree, line_val;
  assign key_agree  = ~key_s2_reg & ~key_s3_reg;
  assign key_active = |(key_agree & ~{key_mask_high_reg, key_mask_low_reg});
  always_comb begin
    line_agree = ext_s2_reg ^ ext_s3_reg;
    line_val   = ~ext_s3_reg;                             // Active-high request level
    line_val[VIC_KEY_LINE] = key_active;
    line_agree[VIC_KEY_LINE] = 1'b0;
  end

  // Filtered levels: a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_lvl_reg  <= 1'b1;
      line_lvl_reg <= '0;
    end else begin
      if (nmi_sync_reg[1] == nmi_sync_reg[2]) nmi_lvl_reg <= nmi_sync_reg[2];
      for (int i = 0; i < NUM_EXT; i++) begin
        if (!line_agree[i]) line_lvl_reg[i] <= line_val[i];
      end
    end
  end

  // Edge detection
  logic               nmi_next_lvl;
  logic               nmi_edge;
  logic [NUM_EXT-1:0] line_next, line_fall;
  assign nmi_next_lvl = (nmi_sync_reg[1] == nmi_sync_reg[2]) ? nmi_sync_reg[2] : nmi_lvl_reg;
  assign nmi_edge = system_control_reg[VIC_NMI_EDGE_BIT]
                  ? (nmi_next_lvl & ~nmi_lvl_reg)
                  : (~nmi_next_lvl & nmi_lvl_reg);
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      line_next[i] = line_agree[i] ? line_lvl_reg[i] : line_val[i];
    end
  end
  assign line_fall = line_next & ~line_lvl_reg;           // Low-going pin edge

  // Watchdog routing
  logic wdt_nmi, wdt_irq;
  assign wdt_nmi = wdt_overflow_i & wdt_nmi_mode_i;
  assign wdt_irq = wdt_overflow_i & ~wdt_nmi_mode_i;

  // Taken strobe from the CPU
  logic taken;
  assign taken = hold_reg & cpu_ack_i;

  // Nonmaskable pending latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_edge || wdt_nmi) begin
      nmi_pend_reg <= 1'b1;
    end else if (taken && vec_reg == VIC_VEC_NMI) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // Edge pending latches per request line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_pend_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_EXT; i++) begin
        if (line_fall[i] && request_enable_reg[i] && request_sense_control_reg[i]) begin
          edge_pend_reg[i] <= 1'b1;
        end else if (cpu_mask_i && !request_sense_control_reg[i]
                     && !request_enable_reg[i]) begin
          edge_pend_reg[i] <= 1'b0;
        end else if (taken && vec_reg == VIC_VEC_EXT0 + 6'(i)) begin
          edge_pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Effective request per line
  logic [NUM_EXT-1:0] ext_req;
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_req[i] = request_sense_control_reg[i] ? edge_pend_reg[i]
                 : (line_lvl_reg[i] & request_enable_reg[i]);
    end
  end

  // Maskable sources in priority order, bit 0 highest
  logic [NUM_EXT+NUM_INT-1:0] mask_src;
  always_comb begin
    mask_src = {int_request_i, ext_req};
    mask_src[NUM_EXT + VIC_WDT_INDEX] = int_request_i[VIC_WDT_INDEX] | wdt_irq;
  end

  // Fixed priority encoder
  logic       sel_valid;
  logic [5:0] sel_vec;
  always_comb begin
    sel_valid = 1'b0;
    sel_vec   = VIC_VEC_NMI;
    if (nmi_pend_reg) begin
      sel_valid = 1'b1;
    end else if (!cpu_mask_i) begin
      for (int i = NUM_EXT + NUM_INT - 1; i >= 0; i--) begin
        if (mask_src[i]) begin
          sel_valid = 1'b1;
          sel_vec   = VIC_VEC_EXT0 + 6'(i);
        end
      end
    end
  end

  // Hold selection until the CPU accepts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= 1'b0;
      vec_reg  <= VIC_VEC_NMI;
    end else if (taken) begin
      hold_reg <= 1'b0;
    end else if (!hold_reg && sel_valid) begin
      hold_reg <= 1'b1;
      vec_reg  <= sel_vec;
    end
  end
  assign cpu_req_o      = hold_reg;
  assign cpu_vec_num_o  = vec_reg;
  assign cpu_vec_addr_o = {9'h000, vec_reg, 1'b0};

  // Documented registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_control_reg        <= VIC_SYSCTL_RST;
      request_sense_control_reg <= VIC_SENSE_RST;
      request_enable_reg        <= VIC_ENABLE_RST;
      key_mask_low_reg          <= VIC_KMASK_LO_RST;
      key_mask_high_reg         <= VIC_KMASK_HI_RST;
      imask_reg                 <= VIC_IMASK_RST;
    end else begin
      if (hit(VIC_SYSCTL_ADDR))
        system_control_reg <= (wb_dat_i & VIC_SYSCTL_WMASK)
                            | (system_control_reg & ~VIC_SYSCTL_WMASK);
      if (hit(VIC_SENSE_ADDR))    request_sense_control_reg <= wb_dat_i;
      if (hit(VIC_ENABLE_ADDR))   request_enable_reg        <= wb_dat_i;
      if (hit(VIC_KMASK_LO_ADDR)) key_mask_low_reg          <= wb_dat_i;
      if (hit(VIC_KMASK_HI_ADDR)) key_mask_high_reg         <= wb_dat_i;
      if (hit(VIC_IMASK_ADDR))    imask_reg                 <= wb_dat_i;
    end
  end

  // Sticky event status, write one to clear, set wins
  logic [7:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[VIC_EV_NMI]   = nmi_edge | wdt_nmi;
    ev_set[VIC_EV_TAKEN] = taken;
    ev_set[VIC_EV_EXT]   = |line_fall;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= ev_set
                  | (status_reg & ~(hit(VIC_STATUS_ADDR) ? wb_dat_i : 8'h00));
    end
  end
  assign irq_o = |(status_reg & imask_reg);

  // Read mux, unmapped reads zero
  always_comb begin
    unique case (wb_adr_i)
      VIC_SYSCTL_ADDR:   rdata_next = system_control_reg;
      VIC_SENSE_ADDR:    rdata_next = request_sense_control_reg;
      VIC_ENABLE_ADDR:   rdata_next = request_enable_reg;
      VIC_KMASK_LO_ADDR: rdata_next = key_mask_low_reg;
      VIC_KMASK_HI_ADDR: rdata_next = key_mask_high_reg;
      VIC_STATUS_ADDR:   rdata_next = status_reg;
      VIC_IMASK_ADDR:    rdata_next = imask_reg;
      VIC_PEND_ADDR:     rdata_next = 8'(edge_pend_reg);
      default:           rdata_next = 8'h00;
    endcase
  end

  // One-wait-state acknowledge with registered data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      ack_reg  <= rd_en;
      if (rd_en) wb_dat_o <= rdata_next;
    end
  end
  assign wb_ack_o = ack_reg;

  // Assertions
  a_mask_blocks_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold_reg && !nmi_pend_reg && cpu_mask_i) |=> !hold_reg)
    else $error("request raised while masked");
  a_nmi_first_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold_reg && nmi_pend_reg) |=> (hold_reg && vec_reg == VIC_VEC_NMI))
    else $error("nonmaskable not chosen first");
  a_vec_stable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (hold_reg && !cpu_ack_i) |=> (hold_reg && $stable(vec_reg)))
    else $error("vector changed before acceptance");
  a_vec_range_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_reg |-> (vec_reg >= VIC_VEC_NMI && vec_reg <= VIC_VEC_LAST))
    else $error("vector outside table");
  a_vec_addr_twice: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_req_o |-> (cpu_vec_addr_o[0] == 1'b0 && cpu_vec_addr_o >= 16'h0006
                   && cpu_vec_addr_o <= 16'h004A))
    else $error("vector address outside table");
  a_edge_clear_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    (cpu_mask_i && request_sense_control_reg == 8'h00 && request_enable_reg == 8'h00
     && !$past(taken)) |=> edge_pend_reg == 8'h00)
    else $error("edge request not cleared");
  a_edge_survives_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_pend_reg[0] && request_sense_control_reg[0] && !taken) |=> edge_pend_reg[0])
    else $error("edge request lost");
  a_prio_lowest_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold_reg && !nmi_pend_reg && !cpu_mask_i && ext_req[0]) |=> vec_reg == VIC_VEC_EXT0)
    else $error("priority order broken");
  a_level_req_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!request_sense_control_reg[7] && request_enable_reg[7] && line_lvl_reg[7]
     && !hold_reg && !cpu_mask_i) |=> hold_reg)
    else $error("level request missing");
  a_wdt_route_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (wdt_overflow_i && wdt_nmi_mode_i) |=> nmi_pend_reg)
    else $error("watchdog nonmaskable lost");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

endmodule : vic_top
`default_nettype wire

//--- vic_cpu_model.sv
// CPU core model that accepts vectored requests after a chosen latency
`default_nettype none
module vic_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cpu_req_i,
  input  wire logic [5:0]  vec_num_i,
  input  wire logic [15:0] vec_addr_i,
  input  wire logic [2:0]  lat_i,
  output logic             cpu_ack_o,
  output logic [15:0]      taken_cnt_o,
  output logic [5:0]       last_num_o,
  output logic [15:0]      last_addr_o,
  output logic             hold_err_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] wait_reg;
  logic [5:0] held_reg;

  // Takes the request at an instruction boundary, lat_i cycles after it appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_ack_o   <= 1'b0;
      taken_cnt_o <= 16'h0000;
      last_num_o  <= 6'h00;
      last_addr_o <= 16'h0000;
      wait_reg    <= 3'h0;
    end else begin
      cpu_ack_o <= 1'b0;
      wait_reg  <= 3'h0;
      if (cpu_req_i && !cpu_ack_o && wait_reg == lat_i) begin
        cpu_ack_o   <= 1'b1;
        taken_cnt_o <= taken_cnt_o + 16'h0001;
        last_num_o  <= vec_num_i;
        last_addr_o <= vec_addr_i;
      end else if (cpu_req_i && !cpu_ack_o) begin
        wait_reg <= wait_reg + 3'h1;
      end
    end
  end

  // Flags a vector that moves while the request waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_err_o <= 1'b0;
      held_reg   <= 6'h00;
    end else begin
      if (cpu_req_i && !cpu_ack_o && wait_reg == 3'h0) held_reg <= vec_num_i;
      if (cpu_req_i && wait_reg != 3'h0 && vec_num_i !== held_reg) hold_err_o <= 1'b1;
    end
  end
endmodule : vic_cpu_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the vectored interrupt controller
`default_nettype none
module tb
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] RA [6] = '{VIC_SYSCTL_ADDR, VIC_SENSE_ADDR, VIC_ENABLE_ADDR,
                                     VIC_KMASK_LO_ADDR, VIC_KMASK_HI_ADDR, 16'hFFC5};
  localparam logic [7:0]  RV [6] = '{8'h09, 8'h00, 8'h00, 8'hBF, 8'hFF, 8'h00};
  logic        clk_i, rst_i, cyc, stb, we, sel, nmi_n, wdt_ov, wdt_nmi, cpu_mask;
  logic        ack, req, cpu_ack, irq, hold_err;
  logic [7:0]  dat, rdat, ext_n, q, d;
  logic [15:0] adr, key_n, vaddr, cnt, base, last_addr;
  logic [25:0] int_req, v;
  logic [5:0]  vnum, last_num;
  logic [2:0]  lat;
  logic [31:0] seed = 32'h0000_0056;
  int          num_errors = 0, n_checks = 0, cycles = 0;

  // Design and CPU partner
  vic_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .nonmask_n_i(nmi_n), .ext_request_lines_n_i(ext_n), .key_sense_inputs_n_i(key_n),
    .int_request_i(int_req), .wdt_overflow_i(wdt_ov), .wdt_nmi_mode_i(wdt_nmi),
    .cpu_mask_i(cpu_mask), .cpu_ack_i(cpu_ack), .cpu_req_o(req), .cpu_vec_num_o(vnum),
    .cpu_vec_addr_o(vaddr), .irq_o(irq));
  vic_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(req), .vec_num_i(vnum),
    .vec_addr_i(vaddr), .lat_i(lat), .cpu_ack_o(cpu_ack), .taken_cnt_o(cnt),
    .last_num_o(last_num), .last_addr_o(last_addr), .hold_err_o(hold_err));

  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Reference: lowest set source wins
  function automatic int low_vec(logic [25:0] r);
    for (int i = 0; i < 26; i++)
      if (r[i]) return 12 + i;
    return 0;
  endfunction : low_vec

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Classic single Wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 1'b1;
    adr <= a;
    dat <= wd;
    // Wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk("bus ack wait", 16'h0002, 16'(n));
  endtask : wb

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(name, {8'h00, e}, {8'h00, q});
  endtask : rd_chk

  task automatic settle();
    tick(20);
    base = cnt;
    lat <= 3'(rnd());
  endtask : settle

  task automatic exp_take(input int e);
    int n;
    n = 0;
    while (cnt === base && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    base = cnt;
    if (n >= 60) chk("request seen", 16'h0001, 16'h0000);
    chk("vector number", 16'(e), {10'h000, last_num});
    chk("vector address", 16'(2 * e), last_addr);
  endtask : exp_take

  task automatic no_take(input int n);
    tick(n);
    chk("request count", base, cnt);
  endtask : no_take

  task automatic pulse_line();
    ext_n[0] <= 1'b0;
    tick(6);
    ext_n[0] <= 1'b1;
    tick(6);
  endtask : pulse_line

  // Reset, register map, then each source family
  initial begin
    {cyc, stb, we, wdt_ov, wdt_nmi, cpu_mask, adr, dat, int_req, lat} = '0;
    {sel, nmi_n, ext_n, key_n, rst_i} = '1;
    tick(20);
    rst_i <= 1'b0;
    tick(4);
    chk("reset vector address", 16'h0006, vaddr);
    for (int i = 0; i < 6; i++) rd_chk("register reset", RA[i], RV[i]);
    for (int i = 0; i < 5; i++) begin
      d = 8'(rnd());
      wb(1'b1, RA[i], d);
      rd_chk("register readback", RA[i], (i == 0) ? ((d & 8'hF7) | 8'h08) : d);
    end
    for (int i = 0; i < 5; i++) wb(1'b1, RA[i], RV[i]);
    settle();
    // Internal sources, boundary and random sets
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 26'h200_0000 : (i == 1) ? 26'h3ff_ffff : 26'(rnd());
      if (v == '0) v = 26'h000_0001;
      int_req <= v;
      exp_take(low_vec(v));
      int_req <= '0;
      settle();
    end
    // Global mask holds back all but the nonmaskable source
    cpu_mask <= 1'b1;
    int_req <= 26'h3ff_ffff;
    no_take(15);
    nmi_n <= 1'b0;
    exp_take(3);
    cpu_mask <= 1'b0;
    exp_take(12);
    int_req <= '0;
    // Rising edge selected, then falling selected again
    wb(1'b1, VIC_SYSCTL_ADDR, 8'h0D);
    settle();
    nmi_n <= 1'b1;
    exp_take(3);
    nmi_n <= 1'b0;
    no_take(15);
    wb(1'b1, VIC_SYSCTL_ADDR, 8'h09);
    nmi_n <= 1'b1;
    no_take(15);
    // Level lines gated by enable
    ext_n <= 8'h7E;
    no_take(15);
    wb(1'b1, VIC_ENABLE_ADDR, 8'h81);
    exp_take(4);
    ext_n <= 8'hFF;
    wb(1'b1, VIC_ENABLE_ADDR, 8'h00);
    settle();
    // Edge request outlives its enable, is served once
    cpu_mask <= 1'b1;
    wb(1'b1, VIC_SENSE_ADDR, 8'h01);
    wb(1'b1, VIC_ENABLE_ADDR, 8'h01);
    pulse_line();
    wb(1'b1, VIC_ENABLE_ADDR, 8'h00);
    rd_chk("edge pending", VIC_PEND_ADDR, 8'h01);
    cpu_mask <= 1'b0;
    exp_take(4);
    no_take(15);
    // Clearing sequence drops a pending edge
    cpu_mask <= 1'b1;
    wb(1'b1, VIC_ENABLE_ADDR, 8'h01);
    pulse_line();
    wb(1'b1, VIC_ENABLE_ADDR, 8'h00);
    wb(1'b1, VIC_SENSE_ADDR, 8'h00);
    rd_chk("edge cleared", VIC_PEND_ADDR, 8'h00);
    wb(1'b1, VIC_SENSE_ADDR, 8'h01);
    cpu_mask <= 1'b0;
    no_take(15);
    wb(1'b1, VIC_SENSE_ADDR, 8'h00);
    // Key inputs fold into line 6
    wb(1'b1, VIC_ENABLE_ADDR, 8'h40);
    key_n <= 16'hFFDF;
    no_take(15);
    key_n <= 16'hFFBF;
    exp_take(10);
    key_n <= 16'hFFFF;
    wb(1'b1, VIC_KMASK_HI_ADDR, 8'hFD);
    settle();
    key_n <= 16'hFDFF;
    exp_take(10);
    key_n <= 16'hFFFF;
    wb(1'b1, VIC_ENABLE_ADDR, 8'h00);
    settle();
    // Watchdog overflow routed either way
    wdt_ov <= 1'b1;
    exp_take(36);
    wdt_ov <= 1'b0;
    wdt_nmi <= 1'b1;
    settle();
    wdt_ov <= 1'b1;
    exp_take(3);
    wdt_ov <= 1'b0;
    wdt_nmi <= 1'b0;
    settle();
    // Event status, mask and interrupt line
    wb(1'b1, VIC_STATUS_ADDR, 8'hFF);
    nmi_n <= 1'b0;
    exp_take(3);
    wb(1'b0, VIC_STATUS_ADDR, 8'h00);
    chk("event status", 16'h0003, {8'h00, q & 8'h03});
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wb(1'b1, VIC_IMASK_ADDR, 8'h01);
    tick(2);
    chk("irq raised", 16'h0001, {15'h0000, irq});
    wb(1'b1, VIC_STATUS_ADDR, 8'h01);
    tick(2);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    chk("vector hold", 16'h0000, {15'h0000, hold_err});
    final_report();
  end
endmodule : tb
`default_nettype wire
